// [ihzp_defines.vh]
// constants for the incremental hysteresis / zero programming block
`ifndef IHZP_DEFINES_VH
`define IHZP_DEFINES_VH
// angle word width: 10 bits, 1024 codes per turn, lsb = 0.3516 deg
`define IHZP_ANG_W        10
// hysteresis 0.7 deg in angle codes (2 x 0.3516 = 0.703)
`define IHZP_HYST_CODES   10'h002
// zero accuracy +-0.35 deg = one angle lsb after rounding
`define IHZP_ZERO_ROUND   10'h000
// programming word length in programming clock cycles
`define IHZP_PROG_BITS    16
// programming word fields
`define IHZP_F_ZERO_LSB   0
`define IHZP_F_REV_BIT    10
// output state after power-up with output_enable_n high
`define IHZP_OUT_PARK     3'h7
`endif

// [ihzp_atan.v]
// ratiometric arctangent of differential sine and cosine samples
`timescale 1ns/1ps
module ihzp_atan #(
  parameter IW = 12,
  parameter AW = 10
) (
  // clock and reset
  input  wire          clk,
  input  wire          resetn,
  // sample in
  input  wire          smpValid,
  input  wire [IW-1:0] sinP,
  input  wire [IW-1:0] sinN,
  input  wire [IW-1:0] cosP,
  input  wire [IW-1:0] cosN,
  // angle out
  output reg  [AW-1:0] angle,
  output reg           angleValid
);
  localparam SW = IW + 3;
  localparam ST_IDLE = 3'h1;
  localparam ST_RUN  = 3'h2;
  localparam ST_DONE = 3'h4;

  reg  [2:0]          state_q;
  reg  signed [SW-1:0] x_q;
  reg  signed [SW-1:0] y_q;
  reg  [AW+1:0]       z_q;
  reg  [3:0]          it_q;
  wire signed [SW-1:0] dx;
  wire signed [SW-1:0] dy;
  reg  [AW+1:0]       atanTab;

  // common mode cancels in the differences
  assign dx = $signed({3'h0, cosP}) - $signed({3'h0, cosN});
  assign dy = $signed({3'h0, sinP}) - $signed({3'h0, sinN});

  // atan(2^-i) in units of 1/4096 turn
  always @* begin
    case (it_q)
      4'h0: atanTab = 12'h200;
      4'h1: atanTab = 12'h12e;
      4'h2: atanTab = 12'h0a0;
      4'h3: atanTab = 12'h051;
      4'h4: atanTab = 12'h029;
      4'h5: atanTab = 12'h014;
      4'h6: atanTab = 12'h00a;
      4'h7: atanTab = 12'h005;
      4'h8: atanTab = 12'h003;
      4'h9: atanTab = 12'h001;
      default: atanTab = 12'h001;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // cordic vectoring, magnitude never enters the angle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= ST_IDLE;
      x_q        <= {SW{1'b0}};
      y_q        <= {SW{1'b0}};
      z_q        <= {(AW+2){1'b0}};
      it_q       <= 4'h0;
      angle      <= {AW{1'b0}};
      angleValid <= 1'b0;
    end else begin
      angleValid <= 1'b0;
      case (state_q)
        ST_IDLE: if (smpValid) begin
          it_q    <= 4'h0;
          state_q <= ST_RUN;
          // fold left half plane by 180 deg first
          if (dx < 0) begin
            x_q <= -dx;
            y_q <= -dy;
            z_q <= 12'h800;
          end else begin
            x_q <= dx;
            y_q <= dy;
            z_q <= 12'h000;
          end
        end
        ST_RUN: begin
          if (y_q < 0) begin
            x_q <= x_q - (y_q >>> it_q);
            y_q <= y_q + (x_q >>> it_q);
            z_q <= z_q - atanTab;
          end else begin
            x_q <= x_q + (y_q >>> it_q);
            y_q <= y_q - (x_q >>> it_q);
            z_q <= z_q + atanTab;
          end
          it_q <= it_q + 4'h1;
          if (it_q == 4'h9)
            state_q <= ST_DONE;
        end
        ST_DONE: begin
          // round to output resolution
          angle      <= z_q[AW+1:2] + {{(AW-1){1'b0}}, z_q[1]};
          angleValid <= 1'b1;
          state_q    <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // ihzp_atan

// [ihzp_incremental.v]
// incremental quadrature back end with hysteresis and otp zero
`timescale 1ns/1ps
`include "ihzp_defines.vh"
module ihzp_incremental #(
  parameter IW = 12,
  parameter AW = `IHZP_ANG_W
) (
  // clock and reset
  input  wire          clk,
  input  wire          resetn,
  // sampled hall signals from front end
  input  wire          smpValid,
  input  wire [IW-1:0] sinP,
  input  wire [IW-1:0] sinN,
  input  wire [IW-1:0] cosP,
  input  wire [IW-1:0] cosN,
  // pins
  input  wire          outputEnableN,
  input  wire          progEnable,
  input  wire          progClk,
  input  wire          progData,
  // otp array
  input  wire [AW:0]   otpWord,
  output reg           otpBurn,
  output reg  [AW:0]   otpBurnWord,
  // quadrature outputs
  output reg           chanA,
  output reg           chanB,
  output reg           index
);
  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [1:0] oenS_q;
  reg [1:0] penS_q;
  reg [1:0] pclkS_q;
  reg [1:0] pdatS_q;
  reg       pclkD_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // pull-up on the enable pin: assume high until sampled
      oenS_q  <= 2'h3;
      penS_q  <= 2'h0;
      pclkS_q <= 2'h0;
      pdatS_q <= 2'h0;
      pclkD_q <= 1'b0;
    end else begin
      oenS_q  <= {oenS_q[0], outputEnableN};
      penS_q  <= {penS_q[0], progEnable};
      pclkS_q <= {pclkS_q[0], progClk};
      pdatS_q <= {pdatS_q[0], progData};
      pclkD_q <= pclkS_q[1];
    end
  end
  // edge taken past the second flop, so a slow pin edge counts once
  wire pclkRise = pclkS_q[1] & ~pclkD_q;

  //////////////////////////////////////////////////////////////////////////
  // angle computation
  wire [AW-1:0] rawAngle;
  wire          rawValid;
  ihzp_atan #(.IW(IW), .AW(AW)) uAtan (
    .clk        (clk),
    .resetn     (resetn),
    .smpValid   (smpValid),
    .sinP       (sinP),
    .sinN       (sinN),
    .cosP       (cosP),
    .cosN       (cosN),
    .angle      (rawAngle),
    .angleValid (rawValid)
  );

  //////////////////////////////////////////////////////////////////////////
  // otp programming shift path
  localparam PS_IDLE  = 4'h1;
  localparam PS_SHIFT = 4'h2;
  localparam PS_DONE  = 4'h4;
  localparam PS_WAIT  = 4'h8;
  reg [3:0]  pst_q;
  reg [15:0] shift_q;
  reg [4:0]  bitCnt_q;
  reg [AW:0] cfg_q;
  reg        cfgLoad_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pst_q       <= PS_IDLE;
      shift_q     <= 16'h0000;
      bitCnt_q    <= 5'h00;
      otpBurn     <= 1'b0;
      otpBurnWord <= {(AW+1){1'b0}};
      cfg_q       <= {(AW+1){1'b0}};
      cfgLoad_q   <= 1'b0;
    end else begin
      otpBurn <= 1'b0;
      // trim word captured once after reset release
      if (!cfgLoad_q) begin
        cfg_q     <= otpWord;
        cfgLoad_q <= 1'b1;
      end
      case (pst_q)
        PS_IDLE: if (penS_q[1]) begin
          bitCnt_q <= 5'h00;
          pst_q    <= PS_SHIFT;
        end
        PS_SHIFT: begin
          // one bit per rising edge, 16 edges
          if (pclkRise) begin
            shift_q  <= {shift_q[14:0], pdatS_q[1]};
            bitCnt_q <= bitCnt_q + 5'h01;
            if (bitCnt_q == `IHZP_PROG_BITS - 1)
              pst_q <= PS_DONE;
          end
          // aborted sequence burns nothing
          if (!penS_q[1])
            pst_q <= PS_IDLE;
        end
        PS_DONE: begin
          // zero field (new index) and reverse bit written together
          if (penS_q[1]) begin
            otpBurn     <= 1'b1;
            otpBurnWord <= shift_q[AW:0];
          end
          pst_q <= PS_WAIT;
        end
        PS_WAIT: begin
          // one burn per enable pulse; a second word needs a new pulse
          if (!penS_q[1])
            pst_q <= PS_IDLE;
        end
        default: pst_q <= PS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // zero offset and direction
  wire          revDir  = cfg_q[`IHZP_F_REV_BIT];
  wire [AW-1:0] zeroPos = cfg_q[AW-1:0];
  reg  [AW-1:0] relAngle;
  always @* begin
    // zero subtracted at full angle resolution
    relAngle = rawAngle - zeroPos + `IHZP_ZERO_ROUND;
    // reverse bit mirrors the count direction
    if (revDir)
      relAngle = {AW{1'b0}} - relAngle;
  end

  //////////////////////////////////////////////////////////////////////////
  // hysteresis tracker: forward moves follow the angle, backward moves
  // follow it plus the band, so each sense keeps its own fixed edges
  localparam [AW-1:0] HYST = `IHZP_HYST_CODES;
  reg  [AW-1:0] pos_q;
  reg           posValid_q;
  wire [AW-1:0] delta    = relAngle - pos_q;
  wire          fwd      = ~delta[AW-1] & (delta != {AW{1'b0}});
  wire          bwd      = delta[AW-1];
  wire [AW-1:0] absDelta = bwd ? ({AW{1'b0}} - delta) : delta;
  wire          farBack  = bwd & (absDelta > HYST);
  wire [AW-1:0] backPos  = relAngle + HYST;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_q      <= {AW{1'b0}};
      posValid_q <= 1'b0;
    end else if (rawValid) begin
      if (!posValid_q) begin
        pos_q      <= relAngle;
        posValid_q <= 1'b1;
      end else if (fwd) begin
        // after a backward run this is already a move beyond the band
        pos_q <= relAngle;
      end else if (farBack) begin
        pos_q <= backPos;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // quadrature encode, 256 steps per turn; a tracked position updates
  // once per sample and jumps straight to the new step, however many steps away
  wire [7:0] step = pos_q[AW-1:AW-8];
  wire       qA   = step[1] ^ step[0];
  wire       qB   = step[1];
  wire       qI   = (step == 8'h00);
  reg        parked_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      parked_q <= 1'b1;
      chanA    <= 1'b1;
      chanB    <= 1'b1;
      index    <= 1'b1;
    end else begin
      // park until enable first seen low
      if (!oenS_q[1])
        parked_q <= 1'b0;
      if (parked_q || !posValid_q) begin
        {chanA, chanB, index} <= `IHZP_OUT_PARK;
      end else begin
        chanA <= qA;
        chanB <= qB;
        index <= qI;
      end
    end
  end
endmodule // ihzp_incremental

// [ihzp_incremental_props.sv]
// assertions on the ports of the incremental block
`timescale 1ns/1ps
module ihzp_incremental_props #(parameter AW = 10) (
  // clock and reset
  input wire        clk,
  input wire        resetn,
  // pins
  input wire        smpValid,
  input wire        outputEnableN,
  input wire        progEnable,
  input wire        progClk,
  input wire        progData,
  // otp and outputs
  input wire        otpBurn,
  input wire [AW:0] otpBurnWord,
  input wire        chanA,
  input wire        chanB,
  input wire        index
);
  reg        seenLow_q;
  reg        pClk_q;
  reg [5:0]  quiet_q;
  reg [4:0]  rise_q;
  reg [15:0] sh_q;
  wire       park = chanA & chanB & index;
  wire       rise = progClk & ~pClk_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seenLow_q <= 1'b0;
      pClk_q <= 1'b0;
      quiet_q <= 6'h00;
      rise_q <= 5'h00;
      sh_q <= 16'h0000;
    end else begin
      seenLow_q <= seenLow_q | ~outputEnableN;
      pClk_q <= progClk;
      // saturate so an idle block never wraps back to a quiet count
      quiet_q <= smpValid ? 6'h00 : quiet_q + {5'h00, quiet_q != 6'h3f};
      rise_q <= !progEnable ? 5'h00 : rise_q + {4'h0, rise & rise_q != 5'h1f};
      sh_q <= rise ? {sh_q[14:0], progData} : sh_q;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence burnPulse;
    otpBurn ##1 !otpBurn;
  endsequence
  a_park_until_low: assert property (!seenLow_q |-> park)
    else $error("outputs left park before enable low");
  a_stay_enabled: assert property (!$past(park) |-> !park)
    else $error("outputs parked again");
  a_burn_single: assert property (otpBurn |-> burnPulse)
    else $error("burn pulse longer than one cycle");
  a_burn_after_16: assert property (otpBurn |-> rise_q >= 5'h10)
    else $error("burn before sixteen clock rises");
  a_burn_word_ok: assert property (otpBurn |-> otpBurnWord == sh_q[AW:0])
    else $error("burn word differs from shifted bits");
  a_idle_no_burn: assert property (!progEnable [*8] |-> !otpBurn)
    else $error("burn outside programming");
  a_gray_step: assert property (!$past(park) |->
    !($changed(chanA) && $changed(chanB)))
    else $error("both channels changed at once");
  a_index_ab_low: assert property (index && !park |-> !chanA && !chanB)
    else $error("index with a channel high");
  a_hold_quiet: assert property (!$past(park) &&
    $changed({chanA, chanB, index}) |-> quiet_q < 6'h28)
    else $error("outputs moved without a sample");
endmodule // ihzp_incremental_props
bind ihzp_incremental ihzp_incremental_props #(.AW(AW)) i_props (
  .clk(clk), .resetn(resetn), .smpValid(smpValid),
  .outputEnableN(outputEnableN), .progEnable(progEnable),
  .progClk(progClk), .progData(progData), .otpBurn(otpBurn),
  .otpBurnWord(otpBurnWord), .chanA(chanA), .chanB(chanB), .index(index));

// [ihzp_prog_model.sv]
// programmer model driving the serial programming pins
`timescale 1ns/1ps
module ihzp_prog_model (
  // command
  input  wire        clk,
  input  wire        start,
  input  wire [15:0] word,
  input  wire [4:0]  nBits,
  // programming pins
  output reg         progEnable = 1'b0,
  output reg         progClk = 1'b0,
  output reg         progData = 1'b0,
  output reg         done = 1'b0
);
  integer i;
  always @(posedge start) begin
    done = 1'b0;
    progEnable = 1'b1;
    repeat (8) @(posedge clk);
    for (i = 0; i < nBits; i = i + 1) begin
      #1 progData = word[15-i];
      repeat (8) @(posedge clk);
      #1 progClk = 1'b1;
      repeat (8) @(posedge clk);
      #1 progClk = 1'b0;
    end
    repeat (8) @(posedge clk);
    // fewer than 16 bits ends as an abort
    #1 progEnable = 1'b0;
    progData = ~progData;
    done = 1'b1;
  end
endmodule // ihzp_prog_model

// [ihzp_incremental_tb.sv]
// self-checking testbench for the incremental block
`timescale 1ns/1ps
module ihzp_incremental_tb;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg         smpValid = 1'b0;
  reg         outputEnableN = 1'b1;
  reg         start = 1'b0;
  reg  [11:0] sinP = 12'h800, sinN = 12'h800, cosP = 12'h800, cosN = 12'h800;
  reg  [10:0] otpWord = 11'h000;
  reg  [10:0] burnWord = 11'h000;
  reg  [4:0]  nBits = 5'h10;
  reg  [1:0]  keep;
  wire        progEnable, progClk, progData, done, otpBurn, chanA, chanB, index;
  wire [10:0] otpBurnWord;
  integer     bad_count = 0, cmp_count = 0, burns = 0, i;
  always #2 clk = ~clk;
  ihzp_incremental i_dut (.clk(clk), .resetn(resetn), .smpValid(smpValid),
    .sinP(sinP), .sinN(sinN), .cosP(cosP), .cosN(cosN),
    .outputEnableN(outputEnableN), .progEnable(progEnable),
    .progClk(progClk), .progData(progData), .otpWord(otpWord),
    .otpBurn(otpBurn), .otpBurnWord(otpBurnWord), .chanA(chanA),
    .chanB(chanB), .index(index));
  ihzp_prog_model i_prog (.clk(clk), .start(start), .word(16'hafff),
    .nBits(nBits), .progEnable(progEnable), .progClk(progClk),
    .progData(progData), .done(done));
  always @(posedge clk) if (otpBurn === 1'b1) begin
    burns = burns + 1;
    burnWord = otpBurnWord;
  end
  task chk(input [10:0] e, input [10:0] g, input string nm);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // one sample at angle code a with field magnitude m
  task ang(input [9:0] a, input real m);
    real t;
    begin
      t = 6.2831853 * a / 1024.0;
      sinP = $rtoi(2048.5 + m * $sin(t));
      sinN = $rtoi(2048.5 - m * $sin(t));
      cosP = $rtoi(2048.5 + m * $cos(t));
      cosN = $rtoi(2048.5 - m * $cos(t));
      smpValid = 1'b1;
      @(posedge clk);
      #1 smpValid = 1'b0;
      repeat (48) @(posedge clk);
      #1;
    end
  endtask
  task rst;
    begin
      resetn = 1'b0;
      repeat (5) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  task prog(input [4:0] n);
    begin
      nBits = n;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      for (i = 0; i < 1000 && done !== 1'b1; i = i + 1) @(posedge clk);
      #1;
      chk(11'h001, {10'h000, done}, "prog done");
    end
  endtask
  task t_park;
    begin
      ang(10'h101, 1000.0);
      chk(11'h007, {chanA, chanB, index}, "park");
      outputEnableN = 1'b0;
      ang(10'h101, 1000.0);
      chk(11'h000, &{chanA, chanB, index}, "unpark");
      outputEnableN = 1'b1;
      ang(10'h105, 1000.0);
      chk(11'h000, &{chanA, chanB, index}, "stay");
      $display("test park done");
    end
  endtask
  task t_cw;
    begin
      for (i = 1; i < 9; i = i + 1) begin
        keep = {chanA, chanB};
        ang(10'h105 + 4 * i, (i % 2) ? 250.0 : 1000.0);
        chk({~keep[0], keep[1]}, {chanA, chanB}, "cw step");
      end
      $display("test cw done");
    end
  endtask
  task t_hyst;
    begin
      keep = {chanA, chanB};
      ang(10'h124, 1000.0);
      ang(10'h123, 1000.0);
      chk(keep, {chanA, chanB}, "hold");
      ang(10'h120, 1000.0);
      chk({keep[0], ~keep[1]}, {chanA, chanB}, "reverse");
      ang(10'h11f, 1000.0);
      chk({keep[0], ~keep[1]}, {chanA, chanB}, "shift");
      ang(10'h125, 1000.0);
      chk(keep, {chanA, chanB}, "return");
      $display("test hyst done");
    end
  endtask
  task t_prog;
    begin
      prog(5'h0a);
      chk(11'h000, burns, "abort");
      prog(5'h10);
      chk(11'h001, burns, "burns");
      chk(11'h7ff, burnWord, "word");
      $display("test prog done");
    end
  endtask
  task t_rev;
    begin
      otpWord = 11'h7ff;
      rst;
      outputEnableN = 1'b0;
      ang(10'h3fe, 1000.0);
      chk(11'h004, {index, chanA, chanB}, "zero");
      for (i = 1; i < 5; i = i + 1) begin
        keep = {chanA, chanB};
        ang(10'h3fe + 4 * i, 1000.0);
        chk({keep[0], ~keep[1]}, {chanA, chanB}, "ccw step");
      end
      $display("test rev done");
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    rst;
    t_park;
    t_cw;
    t_hyst;
    t_prog;
    t_rev;
    finish_test;
  end
  initial begin
    #100000;
    bad_count = bad_count + 1;
    finish_test;
  end
endmodule // ihzp_incremental_tb
